// ==== psc_cfg.svh ====
// Offsets, field positions, reset values and timing figures of the switch
`ifndef PSC_CFG_SVH
`define PSC_CFG_SVH
`define PSC_CLK_PERIOD_NS 100
`define PSC_SECOND_NS 1000000000
`define PSC_FRZ_TOL_S 4'h6
`define PSC_FRZ_STRICT_S 4'h4
`define PSC_TOL_FRAMES 4'hA
`define PSC_N_PRESET 5
`define PSC_OFS_CTRL 8'h00
`define PSC_OFS_TESTS 8'h04
`define PSC_OFS_EXTMODE 8'h08
`define PSC_OFS_HOLD 8'h0C
`define PSC_OFS_STATUS 8'h10
`define PSC_OFS_COUNT 8'h14
`define PSC_OFS_PRESET 8'h18
`define PSC_OFS_ERRSEC 8'h20
`define PSC_OFS_ERRSEC_END 8'h48
`define PSC_CTRL_AUTO 0
`define PSC_CTRL_RETURN 1
`define PSC_CTRL_SBCHECK 2
`define PSC_CTRL_MAN_MAIN 3
`define PSC_CTRL_MAN_SB 4
`define PSC_PRE_SAVE 4
`define PSC_PRE_RECALL 5
`define PSC_RST_HOLD 16'h000A
`endif

// ==== psc_pkg.sv ====
// Types shared by the protection switch control logic
package psc_pkg;
	typedef enum logic [1:0] {
		TEST_OFF = 2'h0,
		TEST_TOL = 2'h1,
		TEST_STRICT = 2'h3
	} psc_test_e;
	typedef enum logic [1:0] {
		EXT_OFF = 2'h0,
		EXT_EDGE = 2'h1,
		EXT_FAULT = 2'h3,
		EXT_INHIBIT = 2'h2
	} psc_ext_mode_e;
	typedef enum logic [1:0] {
		RES_OFF = 2'h0,
		RES_GOOD = 2'h1,
		RES_BAD = 2'h2
	} psc_res_e;
	typedef enum logic {
		SEL_MAIN = 1'b0,
		SEL_STANDBY = 1'b1
	} psc_sel_e;
	typedef struct packed {
		logic auto_on;
		logic auto_return;
		logic standby_check;
		psc_test_e sync_word_check_setting;
		psc_test_e check_packet_setting;
		psc_test_e freeze_setting;
		logic audio_en;
		logic black_en;
		psc_ext_mode_e standby_ext_input_mode;
		psc_ext_mode_e main_ext_input_mode;
		logic [15:0] hold_secs;
	} psc_setup_s;
endpackage : psc_pkg

// ==== psc_top.sv ====
// Protection switch control: fault tests, changeover, counters, presets
`timescale 1ns/100ps
`include "psc_cfg.svh"

module psc_top #(
	parameter int unsigned SEC_CYCLES = `PSC_SECOND_NS / `PSC_CLK_PERIOD_NS,
	parameter int unsigned CNT_W = 16
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rstn,
	// Avalon-MM slave
	input wire logic [7:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [3:0] byteenable,
	input wire logic [31:0] writedata,
	output logic [31:0] readdata,
	output logic waitrequest,
	// Detector results, index 0 main, 1 standby
	input wire logic [1:0] frame_tick,
	input wire logic [1:0] sync_word_err,
	input wire logic [1:0] check_packet_err,
	input wire logic [1:0] audio_lost,
	input wire logic [1:0] audio_silent,
	input wire logic [1:0] black_det,
	input wire logic [1:0] freeze_det,
	// External control inputs, index 0 main, 1 standby
	input wire logic [1:0] ext_ctrl,
	// Switch position and indicators
	output logic select_standby,
	output logic main_selected,
	output logic standby_selected
);
	typedef struct packed {
		logic [1:0] sync1;
		logic [1:0] sync2;
		logic [1:0] sync3;
		logic [31:0] sec_cnt;
		logic sec_tick;
		logic [1:0][3:0] sync_run;
		logic [1:0][3:0] chk_run;
		logic [1:0][3:0] frz_secs;
		logic [1:0][4:0][CNT_W-1:0] errsec;
		logic [15:0] good_secs;
		psc_pkg::psc_sel_e sel;
		logic ind_main;
		logic ind_standby;
		logic [CNT_W-1:0] changeover_count;
		psc_pkg::psc_setup_s cfg;
		psc_pkg::psc_setup_s [`PSC_N_PRESET-1:0] preset;
		logic [`PSC_N_PRESET-1:0] occupied;
		logic waitrequest;
		logic [31:0] readdata;
	} psc_state_s;

	psc_state_s s;
	psc_state_s next_s;

	// Three-state test result
	function automatic psc_pkg::psc_res_e psc_result(input logic en,
		input logic bad);
		if (!en)
			return psc_pkg::RES_OFF;
		return bad ? psc_pkg::RES_BAD : psc_pkg::RES_GOOD;
	endfunction : psc_result

	// Counter step with saturation
	function automatic logic [CNT_W-1:0] psc_sat_inc(
		input logic [CNT_W-1:0] v);
		return (&v) ? v : v + 1'b1;
	endfunction : psc_sat_inc

	// Four-bit run counter step with saturation
	function automatic logic [3:0] psc_run_inc(input logic [3:0] v);
		return (&v) ? v : v + 4'h1;
	endfunction : psc_run_inc

	// Test active for tolerant or strict settings only; code 2 is off
	function automatic logic psc_test_on(input psc_pkg::psc_test_e m);
		return m == psc_pkg::TEST_TOL || m == psc_pkg::TEST_STRICT;
	endfunction : psc_test_on

	// Tolerant or strict judgement of a run of bad frames
	function automatic logic psc_run_bad(input psc_pkg::psc_test_e m,
		input logic [3:0] run);
		case (m)
			psc_pkg::TEST_STRICT: return run != 4'h0;
			psc_pkg::TEST_TOL: return run >= `PSC_TOL_FRAMES;
			default: return 1'b0;
		endcase
	endfunction : psc_run_bad

	always_comb
	begin
		logic [1:0] lvl;
		logic [1:0] fall;
		logic [1:0][4:0] en;
		logic [1:0][4:0] fault;
		logic [1:0][4:0][1:0] res;
		logic [1:0] in_bad;
		logic [3:0] frz_lim;
		logic main_bad;
		logic standby_good;
		logic inhibit;
		logic toggle;
		logic man_main;
		logic man_sb;
		logic taken_wr;
		logic [31:0] rdv;
		logic [7:0] idx;
		psc_pkg::psc_sel_e sel_new;
		psc_pkg::psc_ext_mode_e [1:0] mode;
		lvl = 2'h0;
		fall = 2'h0;
		en = '0;
		fault = '0;
		res = '0;
		in_bad = 2'h0;
		frz_lim = 4'h0;
		main_bad = 1'b0;
		standby_good = 1'b0;
		inhibit = 1'b0;
		toggle = 1'b0;
		man_main = 1'b0;
		man_sb = 1'b0;
		taken_wr = 1'b0;
		rdv = 32'h0000_0000;
		idx = 8'h00;
		sel_new = s.sel;
		mode[0] = s.cfg.main_ext_input_mode;
		mode[1] = s.cfg.standby_ext_input_mode;
		next_s = s;

		// Second-stage output is the settled level
		next_s.sync1 = ext_ctrl;
		next_s.sync2 = s.sync1;
		next_s.sync3 = s.sync2;
		lvl = s.sync2;
		fall = s.sync3 & ~s.sync2;

		// One-second tick
		next_s.sec_tick = 1'b0;
		if (s.sec_cnt >= 32'(SEC_CYCLES - 1))
		begin
			next_s.sec_cnt = 32'h0000_0000;
			next_s.sec_tick = 1'b1;
		end
		else
			next_s.sec_cnt = s.sec_cnt + 32'h0000_0001;

		// Test enables: 0 sync, 1 check, 2 black, 3 audio, 4 freeze
		frz_lim = (s.cfg.freeze_setting == psc_pkg::TEST_STRICT) ?
			`PSC_FRZ_STRICT_S : `PSC_FRZ_TOL_S;
		for (int i = 0; i < 2; i++)
		begin
			en[i][0] =
				psc_test_on(s.cfg.sync_word_check_setting);
			en[i][1] =
				psc_test_on(s.cfg.check_packet_setting);
			en[i][2] = s.cfg.black_en;
			en[i][3] = s.cfg.audio_en;
			en[i][4] = psc_test_on(s.cfg.freeze_setting);
			// Runs of bad frames, counted at each frame boundary
			if (frame_tick[i])
			begin
				next_s.sync_run[i] = sync_word_err[i] ?
					psc_run_inc(s.sync_run[i]) : 4'h0;
				next_s.chk_run[i] = check_packet_err[i] ?
					psc_run_inc(s.chk_run[i]) : 4'h0;
			end
			// Seconds of continuous freeze
			if (!freeze_det[i])
				next_s.frz_secs[i] = 4'h0;
			else if (s.sec_tick)
				next_s.frz_secs[i] = psc_run_inc(s.frz_secs[i]);
			fault[i][0] = psc_run_bad(s.cfg.sync_word_check_setting,
				s.sync_run[i]);
			fault[i][1] = psc_run_bad(s.cfg.check_packet_setting,
				s.chk_run[i]);
			fault[i][2] = en[i][2] && black_det[i];
			fault[i][3] = en[i][3] &&
				(audio_lost[i] || audio_silent[i]);
			fault[i][4] = en[i][4] && freeze_det[i] &&
				s.frz_secs[i] >= frz_lim;
			for (int t = 0; t < 5; t++)
			begin
				res[i][t] = psc_result(en[i][t], fault[i][t]);
				if (fault[i][t] && s.sec_tick)
					next_s.errsec[i][t] =
						psc_sat_inc(s.errsec[i][t]);
			end
			in_bad[i] = |fault[i];
			if (mode[i] == psc_pkg::EXT_FAULT && !lvl[i])
				in_bad[i] = 1'b1;
			if (mode[i] == psc_pkg::EXT_INHIBIT && !lvl[i])
				inhibit = 1'b1;
			if (mode[i] == psc_pkg::EXT_EDGE && fall[i])
				toggle = 1'b1;
		end
		main_bad = in_bad[0];
		standby_good = !s.cfg.standby_check || !in_bad[1];

		// Continuous good time of the main input
		if (main_bad)
			next_s.good_secs = 16'h0000;
		else if (s.sec_tick && !(&s.good_secs))
			next_s.good_secs = s.good_secs + 16'h0001;

		// Bus handshake: answer one cycle after the request appears
		taken_wr = write && !s.waitrequest;
		next_s.waitrequest = !((read || write) && s.waitrequest);
		if (taken_wr && byteenable[0])
		begin
			case (address)
				`PSC_OFS_CTRL:
				begin
					next_s.cfg.auto_on = writedata[`PSC_CTRL_AUTO];
					next_s.cfg.auto_return = writedata[`PSC_CTRL_RETURN];
					next_s.cfg.standby_check =
						writedata[`PSC_CTRL_SBCHECK];
					man_main = writedata[`PSC_CTRL_MAN_MAIN];
					man_sb = writedata[`PSC_CTRL_MAN_SB];
				end
				`PSC_OFS_TESTS:
				begin
					next_s.cfg.sync_word_check_setting =
						psc_pkg::psc_test_e'(writedata[1:0]);
					next_s.cfg.check_packet_setting =
						psc_pkg::psc_test_e'(writedata[3:2]);
					next_s.cfg.freeze_setting =
						psc_pkg::psc_test_e'(writedata[5:4]);
					next_s.cfg.audio_en = writedata[6];
					next_s.cfg.black_en = writedata[7];
				end
				`PSC_OFS_EXTMODE:
				begin
					next_s.cfg.main_ext_input_mode =
						psc_pkg::psc_ext_mode_e'(writedata[1:0]);
					next_s.cfg.standby_ext_input_mode =
						psc_pkg::psc_ext_mode_e'(writedata[3:2]);
				end
				`PSC_OFS_HOLD:
					next_s.cfg.hold_secs[7:0] = writedata[7:0];
				`PSC_OFS_PRESET:
				begin
					for (int p = 0; p < `PSC_N_PRESET; p++)
					begin
						if (writedata[2:0] == 3'(p))
						begin
							if (writedata[`PSC_PRE_SAVE])
							begin
								next_s.preset[p] = s.cfg;
								next_s.occupied[p] = 1'b1;
							end
							else if (writedata[`PSC_PRE_RECALL] &&
								s.occupied[p])
								next_s.cfg = s.preset[p];
						end
					end
				end
				default:
				begin
				end
			endcase
		end
		if (taken_wr && byteenable[1] && address == `PSC_OFS_HOLD)
			next_s.cfg.hold_secs[15:8] = writedata[15:8];

		// Selection, inhibit first, then manual, edge, automatic
		if (inhibit)
			sel_new = s.sel;
		else if (man_sb)
			sel_new = psc_pkg::SEL_STANDBY;
		else if (man_main)
			sel_new = psc_pkg::SEL_MAIN;
		else if (toggle)
			sel_new = (s.sel == psc_pkg::SEL_MAIN) ?
				psc_pkg::SEL_STANDBY : psc_pkg::SEL_MAIN;
		else if (s.sel == psc_pkg::SEL_MAIN && s.cfg.auto_on &&
			main_bad && standby_good)
			sel_new = psc_pkg::SEL_STANDBY;
		else if (s.sel == psc_pkg::SEL_STANDBY && s.cfg.auto_return &&
			!main_bad && s.good_secs >= s.cfg.hold_secs)
			sel_new = psc_pkg::SEL_MAIN;
		next_s.sel = sel_new;
		next_s.ind_main = sel_new == psc_pkg::SEL_MAIN;
		next_s.ind_standby = sel_new == psc_pkg::SEL_STANDBY;
		if (s.sel == psc_pkg::SEL_MAIN && sel_new == psc_pkg::SEL_STANDBY)
			next_s.changeover_count =
				psc_sat_inc(s.changeover_count);

		// Read data, captured when the request is first seen
		case (address)
			`PSC_OFS_CTRL:
				rdv = {29'h0000_0000, s.cfg.standby_check,
					s.cfg.auto_return, s.cfg.auto_on};
			`PSC_OFS_TESTS:
				rdv = {24'h00_0000, s.cfg.black_en, s.cfg.audio_en,
					s.cfg.freeze_setting, s.cfg.check_packet_setting,
					s.cfg.sync_word_check_setting};
			`PSC_OFS_EXTMODE:
				rdv = {28'h000_0000, s.cfg.standby_ext_input_mode,
					s.cfg.main_ext_input_mode};
			`PSC_OFS_HOLD:
				rdv = {16'h0000, s.cfg.hold_secs};
			`PSC_OFS_STATUS:
				rdv = {8'h00, res, lvl, s.ind_standby,
					s.ind_main};
			`PSC_OFS_COUNT:
				rdv = 32'(s.changeover_count);
			`PSC_OFS_PRESET:
				rdv = 32'(s.occupied);
			default:
			begin
				if (address >= `PSC_OFS_ERRSEC &&
					address < `PSC_OFS_ERRSEC_END &&
					address[1:0] == 2'h0)
				begin
					idx = 8'(address - `PSC_OFS_ERRSEC) >> 2;
					if (idx < 8'h05)
						rdv = 32'(s.errsec[0][idx[2:0]]);
					else
						rdv = 32'(s.errsec[1][3'(idx - 8'h05)]);
				end
			end
		endcase
		if (read && s.waitrequest)
			next_s.readdata = rdv;
	end

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			s <= '0;
			s.waitrequest <= 1'b1;
			s.ind_main <= 1'b1;
			s.cfg.hold_secs <= `PSC_RST_HOLD;
		end
		else
			s <= next_s;
	end

	assign readdata = s.readdata;
	assign waitrequest = s.waitrequest;
	assign select_standby = s.sel;
	assign main_selected = s.ind_main;
	assign standby_selected = s.ind_standby;
endmodule : psc_top

// ==== psc_checker.sv ====
// Port assertions for the protection switch control
`timescale 1ns/100ps
module psc_checker (
	// Clock and reset
	input wire logic clk,
	input wire logic rstn,
	// Register bus
	input wire logic [7:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [31:0] writedata,
	input wire logic [31:0] readdata,
	input wire logic waitrequest,
	// Switch
	input wire logic [1:0] ext_ctrl,
	input wire logic select_standby,
	input wire logic main_selected,
	input wire logic standby_selected
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);
	property p_wait_one;
		!waitrequest |=> waitrequest;
	endproperty
	a_wait_one: assert property (p_wait_one)
		else $error("wait low over one cycle");
	property p_wait_req;
		(read || write) && waitrequest |=> !waitrequest;
	endproperty
	a_wait_req: assert property (p_wait_req)
		else $error("request not answered");
	property p_unmapped;
		read && !waitrequest && address >= 8'h48 |-> readdata == 32'h0;
	endproperty
	a_unmapped: assert property (p_unmapped)
		else $error("unmapped read not zero");
	property p_ind_excl;
		main_selected != standby_selected;
	endproperty
	a_ind_excl: assert property (p_ind_excl)
		else $error("indicators not exclusive");
	property p_sel_ind;
		select_standby == standby_selected;
	endproperty
	a_sel_ind: assert property (p_sel_ind)
		else $error("indicator differs from switch");
	sequence s_man(int b);
		write && !waitrequest && address == 8'h00 && writedata[b]
			&& ext_ctrl == 2'h3 && $past(ext_ctrl, 2) == 2'h3;
	endsequence
	property p_man_sb;
		s_man(4) |-> ##[1:2] select_standby;
	endproperty
	a_man_sb: assert property (p_man_sb)
		else $error("manual standby ignored");
	property p_man_main;
		s_man(3) ##0 !writedata[4] |-> ##[1:2] !select_standby;
	endproperty
	a_man_main: assert property (p_man_main)
		else $error("manual main ignored");
	property p_rst_main;
		$rose(rstn) |-> main_selected && !select_standby;
	endproperty
	a_rst_main: assert property (p_rst_main)
		else $error("main not selected after reset");
	c_to_sb: cover property ($rose(select_standby));
	c_to_main: cover property ($fell(select_standby));
	c_read: cover property (read && !waitrequest);
endmodule : psc_checker

bind psc_top psc_checker u_psc_checker (.clk, .rstn, .address, .read,
	.write, .writedata, .readdata, .waitrequest, .ext_ctrl,
	.select_standby, .main_selected, .standby_selected);

// ==== psc_ext_model.sv ====
// External equipment driving the two control inputs, idle high
`timescale 1ns/100ps
module psc_ext_model (
	// Clock
	input wire logic clk,
	// Control levels
	output logic [1:0] ext_ctrl
);
	initial ext_ctrl = 2'h3;
	task automatic drive(input int idx, input logic lvl, input int n);
		@(posedge clk);
		ext_ctrl[idx] <= lvl;
		repeat (n) @(posedge clk);
	endtask : drive
endmodule : psc_ext_model

// ==== tb.sv ====
// Self-checking bench for the protection switch control
`timescale 1ns/100ps
module tb;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic [7:0] address = 8'h00;
	logic read = 1'b0;
	logic write = 1'b0;
	logic [31:0] writedata = 32'h0000_0000;
	logic [1:0] tick, swe, cpe, alost, blk, ext, sil, frz;
	logic [31:0] readdata, q;
	logic waitrequest, select_standby, main_selected, standby_selected;
	int fails = 0;
	int checked = 0;
	int cyc = 0;
	always #50 clk = ~clk;
	psc_top #(.SEC_CYCLES(20)) u_psc_top (.clk, .rstn, .address, .read,
		.write, .byteenable(4'hF), .writedata, .readdata, .waitrequest,
		.frame_tick(tick), .sync_word_err(swe), .check_packet_err(cpe),
		.audio_lost(alost), .audio_silent(sil), .black_det(blk),
		.freeze_det(frz), .ext_ctrl(ext), .select_standby,
		.main_selected, .standby_selected);
	psc_ext_model u_psc_ext_model (.clk, .ext_ctrl(ext));
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp)
		begin
			fails++;
			$display("[ERR] %0t got %h want %h", $time, got, exp);
		end
	endtask : chk
	task automatic bus(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge clk);
		address <= a;
		writedata <= d;
		write <= w;
		read <= !w;
		do
			@(posedge clk);
		while (waitrequest !== 1'b0);
		q = readdata;
		read <= 1'b0;
		write <= 1'b0;
	endtask : bus
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask : wr
	task automatic rdc(input logic [7:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0000_0000);
		chk(q, e);
	endtask : rdc
	task automatic sel(input logic v, input int n);
		for (int i = 0; i < n && select_standby !== v; i++)
			@(posedge clk);
		chk(select_standby, v);
	endtask : sel
	task automatic frame(input logic [1:0] s, input logic [1:0] c);
		@(posedge clk);
		tick <= 2'h3;
		swe <= s;
		cpe <= c;
		@(posedge clk);
		tick <= 2'h0;
	endtask : frame
	task automatic t_reset;
		// Synchronised input levels settle two edges after release
		repeat (2) @(posedge clk);
		rdc(8'h10, 32'h0000_000D);
		rdc(8'h0C, 32'h0000_000A);
		rdc(8'h14, 32'h0000_0000);
		rdc(8'h18, 32'h0000_0000);
		rdc(8'h80, 32'h0000_0000);
		$display("test reset done");
	endtask : t_reset
	task automatic t_manual;
		wr(8'h00, 32'h0000_0010);
		sel(1'b1, 4);
		chk({main_selected, standby_selected}, 2'h1);
		rdc(8'h14, 32'h0000_0001);
		wr(8'h00, 32'h0000_0008);
		sel(1'b0, 4);
		chk({main_selected, standby_selected}, 2'h2);
		$display("test manual done");
	endtask : t_manual
	task automatic t_ext;
		wr(8'h08, 32'h0000_0001);
		u_psc_ext_model.drive(0, 1'b0, 8);
		sel(1'b1, 4);
		rdc(8'h10, 32'h0000_000A);
		u_psc_ext_model.drive(0, 1'b1, 8);
		chk(select_standby, 1'b1);
		wr(8'h08, 32'h0000_0000);
		u_psc_ext_model.drive(0, 1'b0, 8);
		chk(select_standby, 1'b1);
		u_psc_ext_model.drive(0, 1'b1, 8);
		wr(8'h00, 32'h0000_0008);
		sel(1'b0, 4);
		rdc(8'h14, 32'h0000_0002);
		wr(8'h08, 32'h0000_0008);
		u_psc_ext_model.drive(1, 1'b0, 4);
		wr(8'h00, 32'h0000_0010);
		repeat (6) @(posedge clk);
		chk(select_standby, 1'b0);
		u_psc_ext_model.drive(1, 1'b1, 4);
		// Main input in external fault mode, automatic on
		wr(8'h00, 32'h0000_0001);
		wr(8'h08, 32'h0000_0003);
		u_psc_ext_model.drive(0, 1'b0, 8);
		sel(1'b1, 4);
		u_psc_ext_model.drive(0, 1'b1, 8);
		wr(8'h08, 32'h0000_0000);
		wr(8'h00, 32'h0000_0008);
		sel(1'b0, 4);
		rdc(8'h14, 32'h0000_0003);
		$display("test ext done");
	endtask : t_ext
	task automatic t_auto;
		wr(8'h04, 32'h0000_000C);
		wr(8'h0C, 32'h0000_0002);
		wr(8'h00, 32'h0000_0003);
		frame(2'h0, 2'h1);
		sel(1'b1, 8);
		repeat (50) @(posedge clk);
		bus(1'b0, 8'h24, 32'h0000_0000);
		chk(|q[15:0], 1'b1);
		frame(2'h0, 2'h0);
		repeat (10) @(posedge clk);
		chk(select_standby, 1'b1);
		sel(1'b0, 80);
		wr(8'h00, 32'h0000_0007);
		frame(2'h0, 2'h3);
		repeat (50) @(posedge clk);
		chk(select_standby, 1'b0);
		bus(1'b0, 8'h38, 32'h0000_0000);
		chk(|q[15:0], 1'b1);
		frame(2'h0, 2'h0);
		wr(8'h00, 32'h0000_0000);
		rdc(8'h14, 32'h0000_0004);
		$display("test auto done");
	endtask : t_auto
	task automatic t_result;
		wr(8'h04, 32'h0000_00CF);
		wr(8'h00, 32'h0000_0004);
		alost <= 2'h1;
		sil <= 2'h2;
		blk <= 2'h2;
		frame(2'h0, 2'h0);
		rdc(8'h10, 32'h0029_495D);
		alost <= 2'h0;
		sil <= 2'h0;
		blk <= 2'h0;
		wr(8'h04, 32'h0000_0001);
		repeat (9) frame(2'h1, 2'h0);
		bus(1'b0, 8'h10, 32'h0000_0000);
		chk(q[5:4], 2'h1);
		frame(2'h1, 2'h0);
		bus(1'b0, 8'h10, 32'h0000_0000);
		chk(q[5:4], 2'h2);
		$display("test result done");
	endtask : t_result
	task automatic t_freeze;
		// Tolerant: good before 5 s of freeze, bad after 6 s
		wr(8'h04, 32'h0000_0010);
		wr(8'h00, 32'h0000_0000);
		frz <= 2'h1;
		repeat (90) @(posedge clk);
		bus(1'b0, 8'h10, 32'h0000_0000);
		chk(q[13:12], 2'h1);
		repeat (40) @(posedge clk);
		bus(1'b0, 8'h10, 32'h0000_0000);
		chk(q[13:12], 2'h2);
		frz <= 2'h0;
		// Strict: good before 3 s of freeze, bad after 4 s
		wr(8'h04, 32'h0000_0030);
		frz <= 2'h1;
		repeat (50) @(posedge clk);
		bus(1'b0, 8'h10, 32'h0000_0000);
		chk(q[13:12], 2'h1);
		repeat (40) @(posedge clk);
		bus(1'b0, 8'h10, 32'h0000_0000);
		chk(q[13:12], 2'h2);
		repeat (30) @(posedge clk);
		bus(1'b0, 8'h30, 32'h0000_0000);
		chk(|q[15:0], 1'b1);
		frz <= 2'h0;
		wr(8'h04, 32'h0000_0000);
		$display("test freeze done");
	endtask : t_freeze
	task automatic t_preset;
		wr(8'h04, 32'h0000_0040);
		wr(8'h18, 32'h0000_0012);
		rdc(8'h18, 32'h0000_0004);
		wr(8'h04, 32'h0000_0000);
		wr(8'h18, 32'h0000_0023);
		rdc(8'h04, 32'h0000_0000);
		wr(8'h18, 32'h0000_0022);
		rdc(8'h04, 32'h0000_0040);
		$display("test preset done");
	endtask : t_preset
	task automatic results;
		$display("checked %0d fails %0d", checked, fails);
		if (fails == 0 && checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : results
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 5000)
		begin
			fails++;
			$display("[ERR] %0t timeout", $time);
			results();
		end
	end
	initial
	begin
		{tick, swe, cpe, alost, blk, sil, frz} = '0;
		repeat (2) @(posedge clk);
		rstn <= 1'b1;
		t_reset();
		t_manual();
		t_ext();
		t_auto();
		t_result();
		t_freeze();
		t_preset();
		results();
	end
endmodule : tb
